// ===== design/ssv_pkg.sv
// Package for the supply reset supervisor: variants, states, timing constants
package ssv_pkg;

	// Output driver variants
	typedef enum logic [1:0]
	{
		SSV_OD_EXT  = 2'h0,
		SSV_OD_INT  = 2'h1,
		SSV_PP_LOW  = 2'h2,
		SSV_PP_HIGH = 2'h3
	} ssv_variant_t;

	// Sequencer states, Gray coded along power-up, fault, hold, run
	typedef enum logic [1:0]
	{
		SSV_ST_POWERUP = 2'h0,
		SSV_ST_FAULT   = 2'h1,
		SSV_ST_HOLD    = 2'h3,
		SSV_ST_RUN     = 2'h2
	} ssv_state_t;

	// Pin group for one reset output: value and enable
	typedef struct packed
	{
		logic out;
		logic oe;
	} ssv_pin_t;

	// Pull-up enable plus primary and complementary pins
	typedef struct packed
	{
		ssv_pin_t primary;
		ssv_pin_t compl_pin;
		logic     pullup_en;
	} ssv_outs_t;

	// Clock rate
	localparam longint SSV_CLK_HZ        = 100000000;
	// Times as printed
	localparam longint SSV_HOLD_MS       = 200;
	localparam longint SSV_WINDOW_MS     = 1600;
	localparam longint SSV_PRESS_US      = 1000;
	localparam longint SSV_GLITCH_US     = 10;
	// Derived cycle counts (clock rate divided down first, so every count rounds down)
	localparam longint SSV_HOLD_CYC      = SSV_HOLD_MS * (SSV_CLK_HZ / 1000);
	localparam longint SSV_WINDOW_CYC    = SSV_WINDOW_MS * (SSV_CLK_HZ / 1000);
	localparam longint SSV_PRESS_CYC     = SSV_PRESS_US * (SSV_CLK_HZ / 1000000);
	localparam longint SSV_GLITCH_CYC    = SSV_GLITCH_US * (SSV_CLK_HZ / 1000000);
	// Counter width and counter start value
	localparam int     SSV_CNT_W         = 32;
	localparam logic [SSV_CNT_W-1:0] SSV_CNT_ZERO = 32'h0000_0000;
	localparam logic [SSV_CNT_W-1:0] SSV_CNT_ONE  = 32'h0000_0001;

endpackage

// ===== design/ssv_supervisor.sv
// Supply reset supervisor: supply, manual reset and watchdog into a held reset output
`timescale 1ns/1ps

// Contract
// - Four output variants selectable at build
// - Optional complementary output, opposite level except in the push-pull high variant
// - External pull-up variant: low, then float
// - Internal pull-up variant: low, then pulled high
// - Push-pull low variant: low, then high
// - Push-pull high variant: high, then low
// - Complementary output always push-pull
// - Reset on manual, watchdog, supply, power-up
// - Hold reset full delay after causes clear
// - Release needs supply above threshold plus margin; not rechecked after watchdog expiry
// - Reset held during power-up below threshold
// - Rising supply starts hold timer, expiry releases
// - Manual reset active low, pulled up
// - Manual reset ignores short noise pulses
// - Watchdog idle until first falling kick edge
// - Any kick edge restarts watchdog period
// - Missed kick window asserts reset
// - Window default 1.6 s, build option
// - Manual reset needs press delay first
// - Hold delay build option, default 200 ms
module ssv_supervisor
	import ssv_pkg::*;
#(
	parameter ssv_variant_t          VARIANT    = SSV_OD_EXT,
	parameter bit                    HAS_COMPL  = 1'b1,
	parameter bit                    HAS_WDOG   = 1'b1,
	parameter bit                    HAS_MANUAL = 1'b1,
	parameter logic [SSV_CNT_W-1:0] HOLD_CYC   = SSV_CNT_W'(SSV_HOLD_CYC),
	parameter logic [SSV_CNT_W-1:0] WINDOW_CYC = SSV_CNT_W'(SSV_WINDOW_CYC),
	parameter logic [SSV_CNT_W-1:0] PRESS_CYC  = SSV_CNT_W'(SSV_PRESS_CYC),
	parameter logic [SSV_CNT_W-1:0] GLITCH_CYC = SSV_CNT_W'(SSV_GLITCH_CYC)
)
(
	// Clock and reset
	input  wire logic i_sys_clk,
	input  wire logic i_nrst,
	// Supply comparator, above threshold and above threshold plus margin
	input  wire logic i_supply_above_trip,
	input  wire logic i_supply_above_rise_margin,
	// Host-facing inputs
	input  wire logic i_manual_reset_n,
	input  wire logic i_watchdog_kick_in,
	// Primary reset pin
	output logic      o_rst_out,
	output logic      o_rst_oe,
	output logic      o_rst_pullup_en,
	// Complementary active-high reset pin
	output logic      o_rst_compl_out,
	output logic      o_rst_compl_oe,
	// Status
	output logic      o_in_reset,
	output logic      o_wdog_armed
);

	// Synchroniser stages, each with its next value
	logic [1:0]           sync_trip, next_sync_trip;
	logic [1:0]           sync_rise, next_sync_rise;
	logic [1:0]           sync_mr, next_sync_mr;
	logic [1:0]           sync_kick, next_sync_kick;
	logic                 kick_prev, next_kick_prev;

	// Manual reset filter
	logic [SSV_CNT_W-1:0] mr_cnt, next_mr_cnt;
	logic                 mr_active, next_mr_active;

	// Watchdog
	logic                 wd_armed, next_wd_armed;
	logic [SSV_CNT_W-1:0] watchdog_counter, next_watchdog_counter;
	logic                 wd_expire;

	// Sequencer
	ssv_state_t           state, next_state;
	logic [SSV_CNT_W-1:0] hold_cnt, next_hold_cnt;
	logic                 supply_low;
	logic                 supply_ok;
	logic                 kick_rise;
	logic                 kick_fall;

	// Outputs
	ssv_outs_t            outs, next_outs;
	logic                 asserted;

	// Synchronisers; the first stage feeds only the second
	always_comb
	begin
		next_sync_trip = {sync_trip[0], i_supply_above_trip};
		next_sync_rise = {sync_rise[0], i_supply_above_rise_margin};
		next_sync_mr   = {sync_mr[0], i_manual_reset_n};
		next_sync_kick = {sync_kick[0], i_watchdog_kick_in};
		next_kick_prev = sync_kick[1];
	end

	always_ff @(posedge i_sys_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			sync_trip <= 2'h0;
			sync_rise <= 2'h0;
			sync_mr   <= 2'h3;
			sync_kick <= 2'h0;
			kick_prev <= 1'b0;
		end
		else
		begin
			sync_trip <= next_sync_trip;
			sync_rise <= next_sync_rise;
			sync_mr   <= next_sync_mr;
			sync_kick <= next_sync_kick;
			kick_prev <= next_kick_prev;
		end
	end

	// Edge and level decode from settled stages
	assign supply_low = !sync_trip[1];
	assign supply_ok  = sync_rise[1];
	assign kick_rise  = sync_kick[1] && !kick_prev;
	assign kick_fall  = !sync_kick[1] && kick_prev;

	// Manual reset: low must persist past filter and press delay
	always_comb
	begin
		next_mr_cnt    = mr_cnt;
		next_mr_active = mr_active;
		if (!HAS_MANUAL || sync_mr[1])
		begin
			next_mr_cnt    = SSV_CNT_ZERO;
			next_mr_active = 1'b0;
		end
		else if (!mr_active)
		begin
			if (mr_cnt + SSV_CNT_ONE >= GLITCH_CYC + PRESS_CYC)
			begin
				next_mr_active = 1'b1;
			end
			else
			begin
				next_mr_cnt = mr_cnt + SSV_CNT_ONE;
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			mr_cnt    <= SSV_CNT_ZERO;
			mr_active <= 1'b0;
		end
		else
		begin
			mr_cnt    <= next_mr_cnt;
			mr_active <= next_mr_active;
		end
	end

	// Watchdog: armed by first falling edge, any edge restarts the window
	assign wd_expire = wd_armed && (watchdog_counter + SSV_CNT_ONE >= WINDOW_CYC);

	always_comb
	begin
		next_wd_armed         = wd_armed;
		next_watchdog_counter = watchdog_counter;
		if (!HAS_WDOG || asserted)
		begin
			next_wd_armed         = 1'b0;
			next_watchdog_counter = SSV_CNT_ZERO;
		end
		else if (!wd_armed)
		begin
			if (kick_fall)
			begin
				next_wd_armed         = 1'b1;
				next_watchdog_counter = SSV_CNT_ZERO;
			end
		end
		else if (kick_rise || kick_fall)
		begin
			next_watchdog_counter = SSV_CNT_ZERO;
		end
		else if (!wd_expire)
		begin
			next_watchdog_counter = watchdog_counter + SSV_CNT_ONE;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			wd_armed         <= 1'b0;
			watchdog_counter <= SSV_CNT_ZERO;
		end
		else
		begin
			wd_armed         <= next_wd_armed;
			watchdog_counter <= next_watchdog_counter;
		end
	end

	// Sequencer: supply or manual cause enters fault, watchdog expiry enters hold, hold counts after all clear
	always_comb
	begin
		next_state    = state;
		next_hold_cnt = hold_cnt;
		case (state)
			SSV_ST_POWERUP:
			begin
				if (supply_ok)
				begin
					next_state    = SSV_ST_HOLD;
					next_hold_cnt = SSV_CNT_ZERO;
				end
			end
			SSV_ST_FAULT:
			begin
				if (supply_ok && !mr_active)
				begin
					next_state    = SSV_ST_HOLD;
					next_hold_cnt = SSV_CNT_ZERO;
				end
			end
			SSV_ST_HOLD:
			begin
				if (supply_low || mr_active)
				begin
					next_state = SSV_ST_FAULT;
				end
				else if (hold_cnt + SSV_CNT_ONE >= HOLD_CYC)
				begin
					next_state = SSV_ST_RUN;
				end
				else
				begin
					next_hold_cnt = hold_cnt + SSV_CNT_ONE;
				end
			end
			SSV_ST_RUN:
			begin
				if (supply_low || mr_active)
				begin
					next_state = SSV_ST_FAULT;
				end
				else if (wd_expire)
				begin
					next_state    = SSV_ST_HOLD;
					next_hold_cnt = SSV_CNT_ZERO;
				end
			end
			default:
			begin
				next_state = SSV_ST_POWERUP;
			end
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			state    <= SSV_ST_POWERUP;
			hold_cnt <= SSV_CNT_ZERO;
		end
		else
		begin
			state    <= next_state;
			hold_cnt <= next_hold_cnt;
		end
	end

	// Reset is asserted in every state except run
	assign asserted = (state != SSV_ST_RUN);

	// Pin drive per variant
	always_comb
	begin
		next_outs = '0;
		case (VARIANT)
			SSV_OD_EXT:
			begin
				next_outs.primary.out = 1'b0;
				next_outs.primary.oe  = asserted;
			end
			SSV_OD_INT:
			begin
				next_outs.primary.out = 1'b0;
				next_outs.primary.oe  = asserted;
				next_outs.pullup_en   = !asserted;
			end
			SSV_PP_LOW:
			begin
				next_outs.primary.out = !asserted;
				next_outs.primary.oe  = 1'b1;
			end
			SSV_PP_HIGH:
			begin
				next_outs.primary.out = asserted;
				next_outs.primary.oe  = 1'b1;
			end
			default:
			begin
				next_outs.primary.oe  = asserted;
			end
		endcase
		next_outs.compl_pin.out = HAS_COMPL && asserted;
		next_outs.compl_pin.oe  = HAS_COMPL;
	end

	always_ff @(posedge i_sys_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			outs         <= '{'{VARIANT == SSV_PP_HIGH, 1'b1}, '{HAS_COMPL, HAS_COMPL}, 1'b0};
			o_in_reset   <= 1'b1;
			o_wdog_armed <= 1'b0;
		end
		else
		begin
			outs         <= next_outs;
			o_in_reset   <= asserted;
			o_wdog_armed <= wd_armed;
		end
	end

	// Outputs come straight from the outs register
	assign o_rst_out       = outs.primary.out;
	assign o_rst_oe        = outs.primary.oe;
	assign o_rst_pullup_en = outs.pullup_en;
	assign o_rst_compl_out = outs.compl_pin.out;
	assign o_rst_compl_oe  = outs.compl_pin.oe;

endmodule // ssv_supervisor

// ===== bench/ssv_monitor.sv
// Checker of the supervisor pin relations
`timescale 1ns/1ps
module ssv_monitor
#(
	parameter int HOLD = 20,
	parameter int WIN  = 50
)
(
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	// Design inputs
	input wire logic i_supply_above_trip,
	input wire logic i_supply_above_rise_margin,
	input wire logic i_manual_reset_n,
	input wire logic i_watchdog_kick_in,
	// Design outputs
	input wire logic o_rst_out,
	input wire logic o_rst_oe,
	input wire logic o_rst_pullup_en,
	input wire logic o_rst_compl_out,
	input wire logic o_rst_compl_oe,
	input wire logic o_in_reset,
	input wire logic o_wdog_armed
);
	int run_len;
	int quiet;

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_nrst);

	// Length of the present reset and of kick silence while armed
	always_ff @(posedge i_sys_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			run_len <= 0;
			quiet   <= 0;
		end
		else
		begin
			run_len <= o_in_reset ? run_len + 1 : 0;
			quiet   <= (!o_wdog_armed || $changed(i_watchdog_kick_in)) ? 0 : quiet + 1;
		end
	end

	// Button held long enough to count as a press
	sequence s_press;
		(!i_manual_reset_n) [*8];
	endsequence

	a_compl_tracks: assert property (o_rst_compl_oe && $past(o_rst_compl_oe) |->
		o_rst_compl_out == o_in_reset) else $error("complement differs from reset");
	a_compl_driven: assert property ($past(o_rst_compl_oe) |-> o_rst_compl_oe)
		else $error("complement driver released");
	a_od_pull_low: assert property (o_rst_compl_oe |-> !o_rst_out && !o_rst_pullup_en
		&& o_rst_oe == o_in_reset) else $error("open drain pin wrong");
	a_hold_full: assert property ($fell(o_in_reset) |-> run_len >= HOLD)
		else $error("reset released early");
	a_brownout_seen: assert property ($fell(i_supply_above_trip) |-> ##[1:6] o_in_reset)
		else $error("supply drop not seen");
	a_manual_press: assert property (s_press |-> ##[0:6] o_in_reset)
		else $error("manual press not seen");
	a_disarm_reset: assert property (o_in_reset && $past(o_in_reset) |-> !o_wdog_armed)
		else $error("watchdog armed in reset");
	a_kick_expiry: assert property (quiet == WIN + 3 |-> o_in_reset)
		else $error("watchdog did not expire");
endmodule // ssv_monitor

// ===== bench/ssv_host_model.sv
// Host model that kicks the watchdog while it runs
`timescale 1ns/1ps
module ssv_host_model
#(
	parameter int PERIOD = 20
)
(
	// Clock and reset
	input  wire logic i_sys_clk,
	input  wire logic i_nrst,
	// Control and pins
	input  wire logic i_in_reset,
	input  wire logic i_run,
	output logic      o_kick
);
	int cnt;

	// Toggle the kick pin once a period, first edge falling
	always_ff @(posedge i_sys_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			cnt    <= 0;
			o_kick <= 1'b1;
		end
		else if (i_run && !i_in_reset)
		begin
			cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
			if (cnt == PERIOD - 1)
				o_kick <= !o_kick;
		end
	end
endmodule // ssv_host_model

// ===== bench/testbench.sv
// Self-checking bench of the supply reset supervisor
`timescale 1ns/1ps
module testbench;
	localparam int HOLD = 20;
	localparam int WIN  = 50;
	logic i_sys_clk = 1'b0;
	logic i_nrst    = 1'b0;
	logic trip      = 1'b0;
	logic margin    = 1'b0;
	logic mr_n      = 1'b1;
	logic run       = 1'b0;
	logic kick;
	logic o_rst_out, o_rst_oe, o_rst_pullup_en, o_rst_compl_out, o_rst_compl_oe;
	logic o_in_reset, o_wdog_armed;
	wire  [1:3] v_oe, v_out, v_pu, v_cout, v_coe;
	int   n_fail    = 0;
	int   checks    = 0;

	ssv_supervisor #(.HOLD_CYC(32'h14), .WINDOW_CYC(32'h32), .PRESS_CYC(32'h5),
		.GLITCH_CYC(32'h2)) i_ssv_supervisor (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
		.i_supply_above_trip(trip), .i_supply_above_rise_margin(margin),
		.i_manual_reset_n(mr_n), .i_watchdog_kick_in(kick), .o_rst_out(o_rst_out),
		.o_rst_oe(o_rst_oe), .o_rst_pullup_en(o_rst_pullup_en),
		.o_rst_compl_out(o_rst_compl_out), .o_rst_compl_oe(o_rst_compl_oe),
		.o_in_reset(o_in_reset), .o_wdog_armed(o_wdog_armed));
	ssv_host_model #(.PERIOD(20)) i_ssv_host_model (.i_sys_clk(i_sys_clk),
		.i_nrst(i_nrst), .i_in_reset(o_in_reset), .i_run(run), .o_kick(kick));

	// Other pin variants without the complement, sharing all inputs
	for (genvar v = 1; v < 4; v++)
	begin : g_var
		ssv_supervisor #(.VARIANT(ssv_pkg::ssv_variant_t'(v)), .HAS_COMPL(1'b0),
			.HOLD_CYC(32'h14), .WINDOW_CYC(32'h32), .PRESS_CYC(32'h5), .GLITCH_CYC(32'h2))
			i_ssv_supervisor (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
			.i_supply_above_trip(trip), .i_supply_above_rise_margin(margin),
			.i_manual_reset_n(mr_n), .i_watchdog_kick_in(kick), .o_rst_out(v_out[v]),
			.o_rst_oe(v_oe[v]), .o_rst_pullup_en(v_pu[v]), .o_rst_compl_out(v_cout[v]),
			.o_rst_compl_oe(v_coe[v]), .o_in_reset(), .o_wdog_armed());
	end

	// Clock
	initial
		forever #5 i_sys_clk = ~i_sys_clk;

	task automatic cyc(input int n);
		repeat (n) @(posedge i_sys_clk);
		#1;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Cycles until the reset flag reaches a level, bounded
	task automatic wait_lvl(input logic lvl, output int n);
		n = 0;
		while (o_in_reset !== lvl && n < 400)
		begin
			cyc(1);
			n++;
		end
	endtask

	task automatic t_powerup();
		int n;
		cyc(5);
		chk(o_in_reset, 8'h1);
		chk({o_rst_oe, o_rst_out, o_rst_compl_out}, 8'h5);
		chk({v_oe[1], v_out[1], v_pu[1]}, 8'h4);
		chk({v_oe[2], v_out[2], v_pu[2]}, 8'h4);
		chk({v_oe[3], v_out[3], v_pu[3]}, 8'h6);
		chk({v_cout, v_coe}, 8'h0);
		@(posedge i_sys_clk);
		trip <= 1'b1;
		cyc(40);
		chk(o_in_reset, 8'h1);
		@(posedge i_sys_clk);
		margin <= 1'b1;
		wait_lvl(1'b0, n);
		chk(n >= HOLD && n < HOLD + 10, 8'h1);
		chk({o_rst_oe, o_rst_out, o_rst_pullup_en, o_rst_compl_out, o_rst_compl_oe}, 8'h1);
		chk({v_oe[1], v_out[1], v_pu[1]}, 8'h1);
		chk({v_oe[2], v_out[2], v_pu[2]}, 8'h6);
		chk({v_oe[3], v_out[3], v_pu[3]}, 8'h4);
	endtask

	task automatic t_brown();
		int n;
		@(posedge i_sys_clk);
		margin <= 1'b0;
		trip   <= 1'b0;
		cyc(6);
		chk(o_in_reset, 8'h1);
		chk({v_out, v_oe}, 8'h0f);
		@(posedge i_sys_clk);
		trip   <= 1'b1;
		margin <= 1'b1;
		wait_lvl(1'b0, n);
		chk(n >= HOLD && n < HOLD + 10, 8'h1);
	endtask

	task automatic t_manual();
		int n;
		@(posedge i_sys_clk);
		mr_n <= 1'b0;
		repeat (2) @(posedge i_sys_clk);
		mr_n <= 1'b1;
		cyc(20);
		chk(o_in_reset, 8'h0);
		@(posedge i_sys_clk);
		mr_n <= 1'b0;
		repeat (20) @(posedge i_sys_clk);
		mr_n <= 1'b1;
		cyc(1);
		chk(o_in_reset, 8'h1);
		wait_lvl(1'b0, n);
		chk(n >= HOLD - 1 && n < HOLD + 10, 8'h1);
	endtask

	task automatic t_wdog();
		int n;
		cyc(10);
		chk(o_wdog_armed, 8'h0);
		@(posedge i_sys_clk);
		run <= 1'b1;
		cyc(200);
		chk({o_wdog_armed, o_in_reset}, 8'h2);
		@(posedge i_sys_clk);
		run <= 1'b0;
		wait_lvl(1'b1, n);
		chk(n <= WIN + 8, 8'h1);
		cyc(1);
		chk(o_wdog_armed, 8'h0);
		wait_lvl(1'b0, n);
		chk(n >= HOLD - 2 && n < HOLD + 10, 8'h1);
		cyc(WIN + 20);
		chk({o_wdog_armed, o_in_reset}, 8'h0);
	endtask

	task automatic final_report();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		repeat (6) @(posedge i_sys_clk);
		i_nrst <= 1'b1;
		t_powerup();
		t_brown();
		t_manual();
		t_wdog();
		final_report();
	end

	// Hang guard
	initial
	begin
		#100us;
		n_fail++;
		final_report();
	end
endmodule // testbench

bind ssv_supervisor ssv_monitor #(.HOLD(HOLD_CYC), .WIN(WINDOW_CYC)) i_ssv_monitor (
	.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_supply_above_trip(i_supply_above_trip),
	.i_supply_above_rise_margin(i_supply_above_rise_margin),
	.i_manual_reset_n(i_manual_reset_n), .i_watchdog_kick_in(i_watchdog_kick_in),
	.o_rst_out(o_rst_out), .o_rst_oe(o_rst_oe), .o_rst_pullup_en(o_rst_pullup_en),
	.o_rst_compl_out(o_rst_compl_out), .o_rst_compl_oe(o_rst_compl_oe),
	.o_in_reset(o_in_reset), .o_wdog_armed(o_wdog_armed));
